// [verilog/card_coupler_pkg.sv]
package card_coupler_pkg;

  // Byte framing on the serial link
  localparam int BYTE_W = 8;
  localparam int CNT_W = 3;
  localparam int ADDR_W = 3;
  localparam int STRAP_W = 2;
  localparam logic [CNT_W-1:0] CNT_FIRST = 3'h0;
  localparam logic [CNT_W-1:0] CNT_STEP = 3'h1;
  localparam logic [CNT_W-1:0] CNT_ADDR_LAST = 3'h2;
  localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;

  // Address field position inside a byte, most significant bit first
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 5;

  // Fixed upper address bit above the two strapped pin levels
  localparam logic ADDR_TOP = 1'b0;

  // Reset values
  localparam logic [BYTE_W-1:0] CMD_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [STRAP_W-1:0] STRAP_RESET = 2'h3;
  localparam logic [BYTE_W-2:0] SHIFT_CLEAR = 7'h00;

  // Card pin output stage is left idle by this block
  localparam logic PIN_IDLE_OUT = 1'b0;
  localparam logic PIN_IDLE_OE = 1'b0;

  // Frame tracking on the core clock
  typedef enum logic [2:0] {
    FRAME_IDLE = 3'b001,
    FRAME_OPEN = 3'b010,
    FRAME_COMMIT = 3'b100
  } frame_state_t;

endpackage

// [verilog/sync_2ff.sv]
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] nxt_stage1;
  logic [WIDTH-1:0] nxt_stage2;

  // Second stage reads only the first stage
  always_comb begin
    nxt_stage1 = srst ? INIT : asyncIn;
    nxt_stage2 = srst ? INIT : stage1_ff;
  end

  always_ff @(posedge clk) begin
    stage1_ff <= nxt_stage1;
    stage2_ff <= nxt_stage2;
  end

  assign syncOut = stage2_ff;

endmodule

// [verilog/card_coupler_serial_port.sv]
`timescale 1ns/1ps
// Contract
// (RULE_01) Host drives serial clock, chip select and MOSI; device only obeys.
// (RULE_02) Serial clock may idle low or high between transfers.
// (RULE_03) Chip select high: MOSI ignored, MISO off, nothing passed inward.
// (RULE_04) Chip select falling clears shifter, enables lines, aligns bit count.
// (RULE_05) MOSI valid at falling clock edge, shifted in on next rising edge.
// (RULE_06) Bytes travel MSB first; first three bits are address B7..B5.
// (RULE_07) Address bits decoded on the fly to validate MISO in same byte.
// (RULE_08) Device selected only when address matches its two pin levels.
// (RULE_09) Device drives MISO, bits timed from serial clock and chip select.
// (RULE_10) Full byte latched at chip select rising, then functions update.
// (RULE_11) Several addressed bytes may share one chip select frame.
// (RULE_12) Host pauses clock half a high period between consecutive bytes.
// (RULE_13) Write-only command register loaded only from MOSI data.
// (RULE_14) Read-only status register returned only over MISO.
// (RULE_15) Two card pins read as logic inputs giving the interface address.
// (RULE_16) Unmatched byte discarded, no function changed, MISO left undriven.
module card_coupler_serial_port (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic spiClk,
  input wire logic csN,
  input wire logic mosi,
  output logic misoOut,
  output logic misoOe,
  input wire logic auxCardPinAIn,
  output logic auxCardPinAOut,
  output logic auxCardPinAOe,
  input wire logic auxCardPinBIn,
  output logic auxCardPinBOut,
  output logic auxCardPinBOe,
  input wire logic [card_coupler_pkg::BYTE_W-1:0] statusIn,
  output logic [card_coupler_pkg::BYTE_W-1:0] commandWriteRegister,
  output logic commandUpdate,
  output logic frameActive
);
  import card_coupler_pkg::*;

  // Link domain state, cleared while chip select is high except the held byte
  logic [BYTE_W-2:0] shift_ff;
  logic [BYTE_W-2:0] nxt_shift;
  logic [CNT_W-1:0] bitCount_ff;
  logic [CNT_W-1:0] nxt_bitCount;
  logic matched_ff;
  logic nxt_matched;
  logic frameHit_ff;
  logic nxt_frameHit;
  logic [BYTE_W-1:0] byteHold_ff;
  logic [BYTE_W-1:0] nxt_byteHold;
  logic misoBit_ff;
  logic nxt_misoBit;
  logic [BYTE_W-1:0] fullByte;
  logic [ADDR_W-1:0] rxAddr;
  logic [ADDR_W-1:0] ownAddr;
  logic [CNT_W-1:0] misoIndex;

  // Core domain state
  frame_state_t state_ff;
  frame_state_t nxt_state;
  logic hitSeen_ff;
  logic nxt_hitSeen;
  logic [BYTE_W-1:0] cmd_ff;
  logic [BYTE_W-1:0] nxt_cmd;
  logic update_ff;
  logic nxt_update;
  logic [BYTE_W-1:0] statusHold_ff;
  logic [BYTE_W-1:0] nxt_statusHold;
  logic [STRAP_W-1:0] strapHold_ff;
  logic [STRAP_W-1:0] nxt_strapHold;
  logic csSyncN;
  logic hitSync;
  logic [STRAP_W-1:0] pinSync;

  // Crossings into the core clock
  sync_2ff #(
    .WIDTH(1),
    .INIT(1'b1)
  ) u_cs_sync (
    .clk(core_clk),
    .srst(srst),
    .asyncIn(csN),
    .syncOut(csSyncN)
  );

  sync_2ff #(
    .WIDTH(1),
    .INIT(1'b0)
  ) u_hit_sync (
    .clk(core_clk),
    .srst(srst),
    .asyncIn(frameHit_ff),
    .syncOut(hitSync)
  );

  sync_2ff #(
    .WIDTH(STRAP_W),
    .INIT(STRAP_RESET)
  ) u_pin_sync (
    .clk(core_clk),
    .srst(srst),
    .asyncIn({auxCardPinBIn, auxCardPinAIn}),
    .syncOut(pinSync)
  );

  // Byte and address assembly at the link
  always_comb begin
    fullByte = {shift_ff, mosi}; // RULE_06
    rxAddr = {shift_ff[ADDR_W-2:0], mosi}; // RULE_07
    ownAddr = {ADDR_TOP, strapHold_ff}; // RULE_15
    misoIndex = CNT_LAST - bitCount_ff; // RULE_06
  end

  // Next values on each rising serial clock edge
  always_comb begin
    nxt_shift = fullByte[BYTE_W-2:0]; // RULE_05
    nxt_bitCount = bitCount_ff + CNT_STEP;
    nxt_matched = matched_ff;
    nxt_frameHit = frameHit_ff;
    nxt_byteHold = byteHold_ff;
    if (bitCount_ff == CNT_ADDR_LAST) begin
      nxt_matched = (rxAddr == ownAddr); // RULE_08
    end else if (bitCount_ff == CNT_LAST) begin
      nxt_matched = 1'b0; // RULE_11
    end
    if ((bitCount_ff == CNT_LAST) && matched_ff) begin
      nxt_frameHit = 1'b1; // RULE_11
      nxt_byteHold = fullByte; // RULE_13
    end
  end

  // Chip select high holds the link logic cleared
  always_ff @(posedge spiClk or posedge csN) begin // RULE_02
    if (csN) begin
      shift_ff <= SHIFT_CLEAR; // RULE_04
      bitCount_ff <= CNT_FIRST; // RULE_04
      matched_ff <= 1'b0; // RULE_03
      frameHit_ff <= 1'b0; // RULE_03
    end else begin
      shift_ff <= nxt_shift;
      bitCount_ff <= nxt_bitCount;
      matched_ff <= nxt_matched;
      frameHit_ff <= nxt_frameHit;
    end
  end

  // Held byte survives chip select release for the core to take
  always_ff @(posedge spiClk) begin
    byteHold_ff <= nxt_byteHold;
  end

  // MISO bit changes on the falling edge, valid at the next rising edge
  always_comb begin
    nxt_misoBit = 1'b0;
    if (matched_ff) begin
      nxt_misoBit = statusHold_ff[misoIndex]; // RULE_14
    end
  end

  always_ff @(negedge spiClk or posedge csN) begin
    if (csN) begin
      misoBit_ff <= 1'b0; // RULE_03
    end else begin
      misoBit_ff <= nxt_misoBit; // RULE_09
    end
  end

  assign misoOut = misoBit_ff;
  assign misoOe = ~csN & matched_ff; // RULE_16

  // Core side frame tracking
  always_comb begin
    nxt_state = state_ff;
    nxt_hitSeen = hitSeen_ff;
    nxt_cmd = cmd_ff;
    nxt_update = 1'b0;
    nxt_statusHold = statusHold_ff;
    nxt_strapHold = strapHold_ff;
    case (state_ff)
      FRAME_IDLE: begin
        nxt_hitSeen = 1'b0;
        nxt_statusHold = statusIn; // RULE_14
        nxt_strapHold = pinSync; // RULE_15
        if (!csSyncN) begin
          nxt_state = FRAME_OPEN;
        end
      end
      FRAME_OPEN: begin
        if (hitSync) begin
          nxt_hitSeen = 1'b1;
        end
        if (csSyncN) begin
          nxt_state = FRAME_COMMIT;
        end
      end
      FRAME_COMMIT: begin
        if (hitSeen_ff || hitSync) begin
          nxt_cmd = byteHold_ff; // RULE_10
          nxt_update = 1'b1; // RULE_10
        end
        nxt_hitSeen = 1'b0; // RULE_16
        nxt_state = FRAME_IDLE;
      end
      default: begin
        nxt_state = FRAME_IDLE;
        nxt_hitSeen = 1'b0;
      end
    endcase
    if (srst) begin
      nxt_state = FRAME_IDLE;
      nxt_hitSeen = 1'b0;
      nxt_cmd = CMD_RESET;
      nxt_update = 1'b0;
      nxt_statusHold = STATUS_RESET;
      nxt_strapHold = STRAP_RESET;
    end
  end

  always_ff @(posedge core_clk) begin
    state_ff <= nxt_state;
    hitSeen_ff <= nxt_hitSeen;
    cmd_ff <= nxt_cmd;
    update_ff <= nxt_update;
    statusHold_ff <= nxt_statusHold;
    strapHold_ff <= nxt_strapHold;
  end

  assign commandWriteRegister = cmd_ff;
  assign commandUpdate = update_ff;
  assign frameActive = (state_ff == FRAME_OPEN);

  // Card pins serve only as address inputs here
  assign auxCardPinAOut = PIN_IDLE_OUT;
  assign auxCardPinAOe = PIN_IDLE_OE;
  assign auxCardPinBOut = PIN_IDLE_OUT;
  assign auxCardPinBOe = PIN_IDLE_OE;

endmodule

// [verification/card_coupler_serial_port_props.sv]
`timescale 1ns/1ps
module card_coupler_serial_port_props (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic spiClk,
  input wire logic csN,
  input wire logic misoOut,
  input wire logic misoOe,
  input wire logic [card_coupler_pkg::BYTE_W-1:0] statusIn,
  input wire logic [card_coupler_pkg::BYTE_W-1:0] commandWriteRegister,
  input wire logic commandUpdate,
  input wire logic frameActive
);
  import card_coupler_pkg::*;
  logic prev_ff, nxt_prev, riseNow;
  logic [2:0] cnt_ff, nxt_cnt;
  always_comb begin
    riseNow = spiClk & ~prev_ff;
    nxt_prev = spiClk;
    nxt_cnt = csN ? 3'h0 : cnt_ff + {2'h0, riseNow};
  end
  always_ff @(posedge core_clk) begin
    prev_ff <= nxt_prev;
    cnt_ff <= nxt_cnt;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  cs_quiet_a: assert property (csN |-> !misoOe)
    else $error("miso on");
  addr_slot_a: assert property (misoOe |-> cnt_ff >= 3'h3 ||
    (cnt_ff == 3'h2 && riseNow)) else $error("early miso");
  miso_bit_a: assert property (misoOe && !spiClk && !prev_ff &&
    cnt_ff >= 3'h3 |-> misoOut == statusIn[3'h7 - cnt_ff])
    else $error("miso bit");
  upd_pulse_a: assert property (commandUpdate |=> !commandUpdate)
    else $error("long pulse");
  upd_idle_a: assert property (commandUpdate |-> csN && !frameActive)
    else $error("update in frame");
  reg_load_a: assert property (
    $changed(commandWriteRegister) |-> commandUpdate) else $error("reg");
  frame_open_a: assert property ($fell(csN) |-> ##[1:4] frameActive)
    else $error("open");
  frame_end_a: assert property ($rose(csN) |-> ##[1:4] !frameActive)
    else $error("close");
endmodule
bind card_coupler_serial_port card_coupler_serial_port_props chk (
  .core_clk(core_clk), .srst(srst), .spiClk(spiClk), .csN(csN),
  .misoOut(misoOut), .misoOe(misoOe), .statusIn(statusIn),
  .commandWriteRegister(commandWriteRegister),
  .commandUpdate(commandUpdate), .frameActive(frameActive));

// [verification/host_master.sv]
`timescale 1ns/1ps
module host_master (
  output logic spiClk,
  output logic csN,
  output logic mosi,
  input wire logic misoOut,
  input wire logic misoOe
);
  logic idleHigh, last;
  initial begin
    spiClk = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
    last = 1'b0;
  end
  task automatic start(input logic hi);
    idleHigh = hi;
    #2 spiClk = hi;
    #16 csN = 1'b0;
    #16;
  endtask
  task automatic xfer(input logic [7:0] tx, input int nb,
    output logic [7:0] rx, output int oe);
    oe = 0;
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      spiClk = 1'b0;
      mosi = tx[i];
      #16;
      last = misoOe ? misoOut : ~last;
      rx[i] = last;
      oe += int'(misoOe);
      spiClk = 1'b1;
      #16;
    end
    #8 spiClk = idleHigh;
    #8;
  endtask
  task automatic stop();
    #16 csN = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import card_coupler_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic pinA = 1'b1;
  logic pinB = 1'b1;
  logic [BYTE_W-1:0] status = 8'h00;
  logic spiClk, csN, mosi, misoOut, misoOe, upd, act, got;
  logic [BYTE_W-1:0] cmd;
  logic aOut, aOe, bOut, bOe;
  int n_fail = 0;
  int samples_checked = 0;
  always #5 core_clk = ~core_clk;
  host_master host (.spiClk(spiClk), .csN(csN), .mosi(mosi),
    .misoOut(misoOut), .misoOe(misoOe));
  card_coupler_serial_port uut (.core_clk(core_clk), .srst(srst),
    .spiClk(spiClk), .csN(csN), .mosi(mosi), .misoOut(misoOut),
    .misoOe(misoOe), .auxCardPinAIn(pinA), .auxCardPinAOut(aOut),
    .auxCardPinAOe(aOe), .auxCardPinBIn(pinB), .auxCardPinBOut(bOut),
    .auxCardPinBOe(bOe), .statusIn(status), .commandWriteRegister(cmd),
    .commandUpdate(upd), .frameActive(act));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic setup(input logic [1:0] sl, input logic [7:0] st);
    @(negedge core_clk);
    pinA = sl[0];
    pinB = sl[1];
    status = st;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic send(input logic [7:0] tx, input int nb, input int eo);
    logic [7:0] rx;
    int oe;
    host.xfer(tx, nb, rx, oe);
    chk(8'(oe), 8'(eo));
    if (eo == 5) chk({3'h0, rx[4:0]}, {3'h0, status[4:0]});
  endtask
  task automatic await(input logic want);
    got = 1'b0;
    for (int i = 0; i < 20 && !got; i++) begin
      @(negedge core_clk);
      got = upd;
    end
    chk({7'h0, got}, {7'h0, want});
    if (want && !got) report_and_stop();
  endtask
  task automatic t_strap();
    logic [1:0] sl;
    logic [7:0] tx;
    for (int a = 0; a < 4; a++) begin
      sl = a[1:0];
      tx = {ADDR_TOP, sl, ~sl, 3'h5};
      setup(sl, {3'h7, ~sl, sl, 1'b1});
      host.start(sl[0]);
      send(tx, 8, 5);
      host.stop();
      await(1'b1);
      chk(cmd, tx);
      chk({4'h0, aOut, aOe, bOut, bOe}, 8'h00);
    end
  endtask
  task automatic t_miss();
    setup(2'h2, 8'h96);
    host.start(1'b0);
    send(8'hDF, 8, 0);
    send(8'h3F, 8, 0);
    host.stop();
    await(1'b0);
    chk(cmd, 8'h65);
  endtask
  task automatic t_multi();
    setup(2'h1, 8'h4B);
    host.start(1'b1);
    send(8'h3C, 8, 5);
    send(8'h5F, 8, 0);
    send(8'h2B, 8, 5);
    host.stop();
    await(1'b1);
    chk(cmd, 8'h2B);
    await(1'b0);
  endtask
  task automatic t_partial();
    host.start(1'b0);
    send(8'h27, 5, 2);
    host.stop();
    await(1'b0);
    chk(cmd, 8'h2B);
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    srst = 1'b0;
    repeat (4) @(negedge core_clk);
    t_strap();
    t_miss();
    t_multi();
    t_partial();
    report_and_stop();
  end
endmodule
